// *** hw/rerc_pkg.sv ***
// Register map, field layout, codes and limits of the recovery block.
package rerc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS_OFS = 8'h04;
  localparam logic [ADR_W-1:0] REG_COUNT_OFS = 8'h08;

  localparam int CTRL_EEC_BIT = 0;
  localparam int CTRL_AUTO_READ_REALLOC_ENABLE_BIT = 1;
  localparam int CTRL_REALLOC_UNFIXABLE_ENABLE_BIT = 2;
  localparam int CTRL_DISCORR_BIT = 3;
  localparam int CTRL_RETRY_LSB = 8;
  localparam int RETRY_W = 8;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ELIG_BIT = 1;
  localparam int STAT_HARD_BIT = 2;
  localparam int STAT_STABLE_BIT = 3;
  localparam int STAT_RESULT_LSB = 4;
  localparam int COUNT_GROWN_LSB = 16;

  // ****************************************************************
  // Reset values and fixed counts
  // ****************************************************************
  localparam logic [RETRY_W-1:0] RETRY_DEFAULT = 8'h08;
  localparam logic [1:0] STAGE_COUNT = 2'h3;
  localparam logic [3:0] WV_PASSES = 4'ha;
  localparam int SYN_BYTES = 14;
  localparam int ILV_NUM = 3;
  localparam int ILV_CNT_W = 3;
  localparam logic [ILV_CNT_W-1:0] ILV_MAX_ERR = 3'h2;

  // ****************************************************************
  // Result codes and sense values
  // ****************************************************************
  typedef enum logic [2:0] {
    RES_NONE,
    RES_SOFT,
    RES_CORRECTED,
    RES_UNRECOVERED,
    RES_PRIOR_UNFIX
  } rerc_result_t;

  localparam logic [3:0] SENSE_KEY_NONE = 4'h0;
  localparam logic [3:0] SENSE_KEY_RECOVERED = 4'h1;
  localparam logic [3:0] SENSE_KEY_MEDIUM = 4'h3;
  localparam logic [7:0] SENSE_CODE_NONE = 8'h00;
  localparam logic [7:0] SENSE_CODE_UNREC = 8'h11;
  localparam logic [7:0] SENSE_CODE_PRIOR_UNFIX = 8'haa;

endpackage

// *** hw/rerc_ctrl.sv ***
// Read error recovery sequencer with write-verify reallocation and spare policy.

// Contract
// - After an ECC error, re-read up to eight times before double-burst correction.
// - Each re-read gives fresh syndromes; all zero forwards, else keep and re-read.
// - Two consecutive identical syndrome sets make a stable syndrome.
// - Early correction enabled and stable syndrome: correct at once and report outcome.
// - Auto read reallocation allows three times the retry count of re-reads.
// - First stage: eight plain re-reads before anything else; stop on success.
// - Second stage: on stable syndrome try correction and mark sector eligible.
// - Third stage: stable marks eligible; correct whenever ECC correctable.
// - After a corrected or uncorrectable outcome, start reallocation.
// - Reallocate only if eligible and auto enabled; uncorrectable also needs unfixable enable.
// - Ten write-verify passes; any error moves data to spare and logs grown defect.
// - Uncorrectable data written with special ID; later reads report sense 3,0AA.
// - Clean write-verify leaves data in place; uncorrectable still reports on reread.
// - Disable-correction re-reads up to the retry count; zero count means none.
// - Recovery by a re-read with all syndromes zero is a soft error.
// - Recovery via stable syndrome, or no recovery at all, is a hard error.
// - One spare per cylinder; first factory defect uses inline sparing.
// - Further factory defects on a cylinder go to nearest spare on nearby cylinder.
// - Grown defects never use inline sparing; remap to a nearby cylinder spare.
// - Double-burst sectors are grown defects; failed data stored flagged as ECC error. The code counts a grown defect only on a write-verify error.
// - A syndrome set is twelve ECC plus two cross-check syndromes.
// - Double-burst correction succeeds only with at most two bad bytes per interleave.
module rerc_ctrl #(
  parameter int NUM_CYL = 64,
  parameter int CYL_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rerc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Read channel and ECC unit.
  input wire logic err_i,
  input wire logic prior_unfix_i,
  input wire logic [CYL_W-1:0] err_cyl_i,
  output logic reread_req_o,
  input wire logic syn_valid_i,
  input wire logic [rerc_pkg::SYN_BYTES*8-1:0] syn_i,
  input wire logic [rerc_pkg::ILV_NUM*rerc_pkg::ILV_CNT_W-1:0] ilv_cnt_i,
  output logic corr_apply_o,
  // Write-verify path.
  output logic wv_req_o,
  output logic wv_special_id_o,
  input wire logic wv_done_i,
  input wire logic wv_err_i,
  // Spare allocation and factory defects.
  input wire logic fdef_i,
  input wire logic [CYL_W-1:0] fdef_cyl_i,
  output logic spare_cmd_o,
  output logic spare_inline_o,
  output logic [CYL_W-1:0] spare_cyl_o,
  // Host side report.
  output logic host_fwd_o,
  output logic done_o,
  output logic [2:0] result_o,
  output logic [3:0] sense_key_o,
  output logic [7:0] sense_code_o
);
  import rerc_pkg::*;

  localparam int SYN_W = SYN_BYTES * 8;
  localparam int CNT_W = RETRY_W + 2;
  localparam int CIDX_W = $clog2(NUM_CYL);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_REREAD,
    ST_WAIT,
    ST_EXHAUST,
    ST_CHECK,
    ST_WV_REQ,
    ST_WV_WAIT,
    ST_REMAP,
    ST_DONE
  } rerc_state_t;

  typedef struct packed {
    rerc_state_t st;
    logic eec;
    logic auto_read_realloc_enable;
    logic realloc_unfixable_enable;
    logic dis_corr;
    logic [RETRY_W-1:0] retry;
    logic [CNT_W-1:0] attempts;
    logic have_prev;
    logic [SYN_W-1:0] prev_syn;
    logic last_ok;
    logic eligible;
    logic stable_seen;
    logic corrected;
    logic hard;
    logic [3:0] wv_pass;
    logic [CYL_W-1:0] cyl;
    logic [NUM_CYL-1:0] inline_used;
    logic [15:0] grown_cnt;
    rerc_result_t result;
    logic ack;
    logic [31:0] rdata;
    logic reread_req;
    logic corr_apply;
    logic wv_req;
    logic spare_cmd;
    logic spare_inline;
    logic [CYL_W-1:0] spare_cyl;
    logic host_fwd;
    logic done;
    logic [3:0] sense_key;
    logic [7:0] sense_code;
  } rerc_regs_t;

  rerc_regs_t r_reg;
  rerc_regs_t r_next;

  // ****************************************************************
  // Syndrome checks
  // ****************************************************************

  // Bytes compare singly; a match needs all fourteen equal.
  logic [SYN_BYTES-1:0] byte_eq;
  logic [SYN_BYTES-1:0] byte_zero;
  genvar gi;
  generate
    for (gi = 0; gi < SYN_BYTES; gi++) begin : g_syn
      assign byte_eq[gi] = (syn_i[gi*8 +: 8] == r_reg.prev_syn[gi*8 +: 8]);
      assign byte_zero[gi] = (syn_i[gi*8 +: 8] == 8'h00);
    end
  endgenerate

  // Correctable if no interleave has over two bad bytes.
  function automatic logic ilv_correctable(input logic [ILV_NUM*ILV_CNT_W-1:0] cnt);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ILV_NUM; i++) begin
      if (cnt[i*ILV_CNT_W +: ILV_CNT_W] > ILV_MAX_ERR) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Decode shared by reads and writes.
  function automatic logic is_reg(input logic [ADR_W-1:0] a, input logic [ADR_W-1:0] ofs);
    return a == ofs;
  endfunction

  logic syn_zero;
  logic stable;
  logic corr_ok;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] rc_w;
  logic [1:0] stage;

  // Stage is the re-read index over the retry count.
  always_comb begin
    rc_w = {2'b00, r_reg.retry};
    syn_zero = &byte_zero;
    stable = r_reg.have_prev && (&byte_eq);
    corr_ok = !r_reg.dis_corr && ilv_correctable(ilv_cnt_i);
    limit = r_reg.auto_read_realloc_enable ? CNT_W'(rc_w * STAGE_COUNT) : rc_w;
    if (r_reg.attempts < rc_w) begin
      stage = 2'd0;
    end else if (r_reg.attempts < CNT_W'(rc_w << 1)) begin
      stage = 2'd1;
    end else begin
      stage = 2'd2;
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Bus slave, recovery sequencer and spare policy.
  always_comb begin
    logic cont;
    cont = 1'b0;
    r_next = r_reg;
    r_next.reread_req = 1'b0;
    r_next.corr_apply = 1'b0;
    r_next.wv_req = 1'b0;
    r_next.spare_cmd = 1'b0;
    r_next.host_fwd = 1'b0;
    r_next.done = 1'b0;

    // Answer one cycle after the strobe, then drop for a cycle.
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
    r_next.rdata = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      if (wb_we_i && is_reg(wb_adr_i, REG_CTRL_OFS)) begin
        if (wb_sel_i[0]) begin
          r_next.eec = wb_dat_i[CTRL_EEC_BIT];
          r_next.auto_read_realloc_enable = wb_dat_i[CTRL_AUTO_READ_REALLOC_ENABLE_BIT];
          r_next.realloc_unfixable_enable = wb_dat_i[CTRL_REALLOC_UNFIXABLE_ENABLE_BIT];
          r_next.dis_corr = wb_dat_i[CTRL_DISCORR_BIT];
        end
        if (wb_sel_i[1]) begin
          r_next.retry = wb_dat_i[CTRL_RETRY_LSB +: RETRY_W];
        end
      end
      if (!wb_we_i) begin
        if (is_reg(wb_adr_i, REG_CTRL_OFS)) begin
          r_next.rdata[CTRL_EEC_BIT] = r_reg.eec;
          r_next.rdata[CTRL_AUTO_READ_REALLOC_ENABLE_BIT] = r_reg.auto_read_realloc_enable;
          r_next.rdata[CTRL_REALLOC_UNFIXABLE_ENABLE_BIT] = r_reg.realloc_unfixable_enable;
          r_next.rdata[CTRL_DISCORR_BIT] = r_reg.dis_corr;
          r_next.rdata[CTRL_RETRY_LSB +: RETRY_W] = r_reg.retry;
        end else if (is_reg(wb_adr_i, REG_STATUS_OFS)) begin
          r_next.rdata[STAT_BUSY_BIT] = (r_reg.st != ST_IDLE);
          r_next.rdata[STAT_ELIG_BIT] = r_reg.eligible;
          r_next.rdata[STAT_HARD_BIT] = r_reg.hard;
          r_next.rdata[STAT_STABLE_BIT] = r_reg.stable_seen;
          r_next.rdata[STAT_RESULT_LSB +: 3] = r_reg.result;
        end else if (is_reg(wb_adr_i, REG_COUNT_OFS)) begin
          r_next.rdata[CNT_W-1:0] = r_reg.attempts;
          r_next.rdata[COUNT_GROWN_LSB +: 16] = r_reg.grown_cnt;
        end
      end
    end

    unique case (r_reg.st)
      ST_IDLE: begin
        if (err_i) begin
          r_next.attempts = '0;
          r_next.have_prev = 1'b0;
          r_next.eligible = 1'b0;
          r_next.stable_seen = 1'b0;
          r_next.corrected = 1'b0;
          r_next.hard = 1'b0;
          r_next.last_ok = 1'b0;
          r_next.wv_pass = '0;
          r_next.cyl = err_cyl_i;
          r_next.result = RES_NONE;
          if (prior_unfix_i) begin
            // Flagged data is reported at once.
            r_next.result = RES_PRIOR_UNFIX;
            r_next.st = ST_DONE;
          end else if (limit == '0) begin
            r_next.st = ST_EXHAUST;
          end else begin
            r_next.st = ST_REREAD;
          end
        end else if (fdef_i) begin
          // First factory defect on a cylinder slips inline; later ones go nearby.
          r_next.spare_cmd = 1'b1;
          r_next.spare_cyl = fdef_cyl_i;
          r_next.spare_inline = !r_reg.inline_used[CIDX_W'(fdef_cyl_i)];
          r_next.inline_used[CIDX_W'(fdef_cyl_i)] = 1'b1;
        end
      end
      ST_REREAD: begin
        r_next.reread_req = 1'b1;
        r_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (syn_valid_i) begin
          r_next.attempts = r_reg.attempts + 1'b1;
          r_next.last_ok = corr_ok;
          if (stable) begin
            r_next.stable_seen = 1'b1;
          end
          if (syn_zero) begin
            r_next.host_fwd = 1'b1;
            r_next.result = RES_SOFT;
            r_next.st = ST_DONE;
          end else if (stage == 2'd0) begin
            // Plain re-reads unless early correction sees a stable set.
            if (r_reg.eec && stable && corr_ok) begin
              r_next.corrected = 1'b1;
              r_next.eligible = 1'b1;
            end else begin
              cont = 1'b1;
            end
          end else if (stage == 2'd1) begin
            if (stable && !r_reg.dis_corr) begin
              r_next.eligible = 1'b1;
            end
            if (stable && corr_ok) begin
              r_next.corrected = 1'b1;
            end else begin
              cont = 1'b1;
            end
          end else begin
            if (stable) begin
              r_next.eligible = 1'b1;
            end
            if (corr_ok) begin
              r_next.corrected = 1'b1;
              r_next.eligible = 1'b1;
            end else begin
              cont = 1'b1;
            end
          end
          if (!syn_zero && !cont) begin
            r_next.corr_apply = 1'b1;
            r_next.hard = 1'b1;
            r_next.result = RES_CORRECTED;
            r_next.host_fwd = 1'b1;
            r_next.st = ST_CHECK;
          end else if (cont) begin
            // Keep this set for the next stability test.
            r_next.prev_syn = syn_i;
            r_next.have_prev = 1'b1;
            if (r_next.attempts >= limit) begin
              r_next.st = ST_EXHAUST;
            end else begin
              r_next.st = ST_REREAD;
            end
          end
        end
      end
      ST_EXHAUST: begin
        // Re-reads ran out: try double-burst correction if allowed.
        r_next.hard = 1'b1;
        if (r_reg.last_ok && !r_reg.dis_corr && r_reg.attempts != '0) begin
          r_next.corrected = 1'b1;
          r_next.eligible = 1'b1;
          r_next.corr_apply = 1'b1;
          r_next.host_fwd = 1'b1;
          r_next.result = RES_CORRECTED;
        end else begin
          r_next.result = RES_UNRECOVERED;
        end
        r_next.st = ST_CHECK;
      end
      ST_CHECK: begin
        if (r_reg.eligible && r_reg.auto_read_realloc_enable && (r_reg.corrected || r_reg.realloc_unfixable_enable)) begin
          r_next.st = ST_WV_REQ;
        end else begin
          r_next.st = ST_DONE;
        end
      end
      ST_WV_REQ: begin
        r_next.wv_req = 1'b1;
        r_next.st = ST_WV_WAIT;
      end
      ST_WV_WAIT: begin
        if (wv_done_i) begin
          if (wv_err_i) begin
            r_next.st = ST_REMAP;
          end else if (r_reg.wv_pass == WV_PASSES - 4'h1) begin
            r_next.st = ST_DONE;
          end else begin
            r_next.wv_pass = r_reg.wv_pass + 4'h1;
            r_next.st = ST_WV_REQ;
          end
        end
      end
      ST_REMAP: begin
        // Grown defects go to a nearby spare.
        r_next.spare_cmd = 1'b1;
        r_next.spare_inline = 1'b0;
        r_next.spare_cyl = r_reg.cyl;
        r_next.grown_cnt = r_reg.grown_cnt + 16'h0001;
        r_next.st = ST_DONE;
      end
      ST_DONE: begin
        r_next.done = 1'b1;
        unique case (r_reg.result)
          RES_SOFT, RES_CORRECTED: begin
            r_next.sense_key = SENSE_KEY_RECOVERED;
            r_next.sense_code = SENSE_CODE_NONE;
          end
          RES_PRIOR_UNFIX: begin
            r_next.sense_key = SENSE_KEY_MEDIUM;
            r_next.sense_code = SENSE_CODE_PRIOR_UNFIX;
          end
          RES_UNRECOVERED: begin
            r_next.sense_key = SENSE_KEY_MEDIUM;
            r_next.sense_code = SENSE_CODE_UNREC;
          end
          default: begin
            r_next.sense_key = SENSE_KEY_NONE;
            r_next.sense_code = SENSE_CODE_NONE;
          end
        endcase
        r_next.st = ST_IDLE;
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset loads constants only; retry starts at its default.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.retry <= RETRY_DEFAULT;
      r_reg.result <= RES_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Uncorrectable data is rewritten with the special ID so later reads flag it.
  assign wv_special_id_o = !r_reg.corrected;
  assign wb_dat_o = r_reg.rdata;
  assign wb_ack_o = r_reg.ack;
  assign reread_req_o = r_reg.reread_req;
  assign corr_apply_o = r_reg.corr_apply;
  assign wv_req_o = r_reg.wv_req;
  assign spare_cmd_o = r_reg.spare_cmd;
  assign spare_inline_o = r_reg.spare_inline;
  assign spare_cyl_o = r_reg.spare_cyl;
  assign host_fwd_o = r_reg.host_fwd;
  assign done_o = r_reg.done;
  assign result_o = r_reg.result;
  assign sense_key_o = r_reg.sense_key;
  assign sense_code_o = r_reg.sense_code;

endmodule

// *** sim/rerc_ctrl_monitor.sv ***
// Checker bound to every recovery block.
module rerc_ctrl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic err_i,
  input wire logic prior_unfix_i,
  input wire logic reread_req_o,
  input wire logic syn_valid_i,
  input wire logic [rerc_pkg::SYN_BYTES*8-1:0] syn_i,
  input wire logic wv_done_i,
  input wire logic wv_err_i,
  input wire logic spare_cmd_o,
  input wire logic spare_inline_o,
  input wire logic host_fwd_o,
  input wire logic done_o,
  input wire logic [2:0] result_o,
  input wire logic [3:0] sense_key_o,
  input wire logic [7:0] sense_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Helper state and properties
  // ****************************************************************
  logic pend_reg;
  logic busy_reg;

  // Open re-read and busy span, not visible at the ports.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      pend_reg <= reread_req_o | (pend_reg & ~syn_valid_i);
      busy_reg <= err_i | (busy_reg & ~done_o);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_zero_syn;
    pend_reg && syn_valid_i && syn_i == '0;
  endsequence
  sequence s_soft_end;
    host_fwd_o ##1 (done_o && result_o == 3'h1);
  endsequence
  sequence s_prior_err;
    err_i && prior_unfix_i && !busy_reg;
  endsequence

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stray read data");
  AST_ONE_REREAD: assert property (reread_req_o |-> busy_reg && !pend_reg)
    else $error("stray re-read");
  AST_SOFT_FWD: assert property (s_zero_syn |=> s_soft_end)
    else $error("soft not forwarded");
  AST_PRIOR: assert property (s_prior_err |=> result_o == 3'h4 ##1 done_o)
    else $error("flag not reported");
  AST_PRIOR_SENSE: assert property (done_o && result_o == 3'h4 |->
    sense_key_o == 4'h3 && sense_code_o == 8'haa)
    else $error("flag sense wrong");
  AST_GROWN: assert property (wv_done_i && wv_err_i |->
    ##[1:8] (spare_cmd_o && !spare_inline_o))
    else $error("no nearby spare");
  AST_DONE_PULSE: assert property (done_o |=> !done_o)
    else $error("long done");
endmodule

bind rerc_ctrl rerc_ctrl_monitor rerc_ctrl_monitor_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .err_i, .prior_unfix_i, .reread_req_o, .syn_valid_i, .syn_i,
  .wv_done_i, .wv_err_i, .spare_cmd_o, .spare_inline_o, .host_fwd_o, .done_o, .result_o,
  .sense_key_o, .sense_code_o);

// *** sim/rerc_partner.sv ***
// Model of read channel and write-verify path.
module rerc_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reread_req_i,
  input wire logic wv_req_i,
  input wire logic clr_i,
  input wire logic [7:0] ok_at_i,
  input wire logic stable_i,
  input wire logic bad_ilv_i,
  input wire logic wv_fail_i,
  input wire logic slow_i,
  output logic syn_valid_o,
  output logic [rerc_pkg::SYN_BYTES*8-1:0] syn_o,
  output logic [8:0] ilv_cnt_o,
  output logic wv_done_o,
  output logic wv_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Answer timing and data
  // ****************************************************************
  logic [2:0] rr_reg;
  logic [2:0] wv_reg;
  logic [7:0] n_reg;

  // Answers come two or five cycles after the request; idle lines toggle so stale data fails.
  always_ff @(posedge clk_i) begin
    syn_valid_o <= 1'b0;
    wv_done_o <= 1'b0;
    syn_o <= ~syn_o;
    ilv_cnt_o <= ~ilv_cnt_o;
    wv_err_o <= ~wv_err_o;
    if (rst_i || clr_i) begin
      rr_reg <= 3'h0;
      wv_reg <= 3'h0;
      n_reg <= 8'h00;
      syn_o <= '0;
      ilv_cnt_o <= 9'h000;
      wv_err_o <= 1'b0;
    end else begin
      if (reread_req_i) begin
        rr_reg <= slow_i ? 3'h4 : 3'h1;
        n_reg <= n_reg + 8'h01;
      end else if (rr_reg == 3'h1) begin
        rr_reg <= 3'h0;
        syn_valid_o <= 1'b1;
        // Stable sets repeat; others follow the re-read number.
        syn_o <= (n_reg == ok_at_i) ? '0 : stable_i ? {14{8'h5a}} : {14{n_reg}};
        ilv_cnt_o <= bad_ilv_i ? 9'h0db : 9'h049;
      end else if (rr_reg != 3'h0) begin
        rr_reg <= rr_reg - 3'h1;
      end
      if (wv_req_i) begin
        wv_reg <= slow_i ? 3'h4 : 3'h1;
      end else if (wv_reg == 3'h1) begin
        wv_reg <= 3'h0;
        wv_done_o <= 1'b1;
        wv_err_o <= wv_fail_i;
      end else if (wv_reg != 3'h0) begin
        wv_reg <= wv_reg - 3'h1;
      end
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking recovery block bench.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rerc_pkg::*;
  // ****************************************************************
  // Signals, instances and helpers
  // ****************************************************************
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, ok_at_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, err_i = 1'b0, prior_unfix_i = 1'b0, fdef_i = 1'b0, reread_req_o, syn_valid_i;
  logic [15:0] err_cyl_i = 16'h0, fdef_cyl_i = 16'h0, spare_cyl_o, cyl_seen;
  logic [111:0] syn_i;
  logic [8:0] ilv_cnt_i;
  logic corr_apply_o, wv_req_o, wv_special_id_o, wv_done_i, wv_err_i, spare_cmd_o;
  logic spare_inline_o, host_fwd_o, done_o, sid_seen, inl_seen;
  logic clr_i = 1'b0, stable_i = 1'b0, bad_ilv_i = 1'b0, wv_fail_i = 1'b0, slow_i = 1'b0;
  logic [2:0] result_o;
  logic [3:0] sense_key_o;
  logic [7:0] sense_code_o;
  int mismatches = 0, tests_run = 0, n_rr = 0, n_wv = 0, n_sp = 0, n_fwd = 0, n_corr = 0;

  rerc_ctrl #(.NUM_CYL(64), .CYL_W(16)) rerc_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .err_i, .prior_unfix_i,
    .err_cyl_i, .reread_req_o, .syn_valid_i, .syn_i, .ilv_cnt_i, .corr_apply_o, .wv_req_o,
    .wv_special_id_o, .wv_done_i, .wv_err_i, .fdef_i, .fdef_cyl_i, .spare_cmd_o,
    .spare_inline_o, .spare_cyl_o, .host_fwd_o, .done_o, .result_o, .sense_key_o,
    .sense_code_o);
  rerc_partner rerc_partner_i (.clk_i, .rst_i, .reread_req_i(reread_req_o),
    .wv_req_i(wv_req_o), .clr_i, .ok_at_i, .stable_i, .bad_ilv_i, .wv_fail_i, .slow_i,
    .syn_valid_o(syn_valid_i), .syn_o(syn_i), .ilv_cnt_o(ilv_cnt_i),
    .wv_done_o(wv_done_i), .wv_err_o(wv_err_i));

  // 20 ns clock.
  initial forever #10 clk_i = ~clk_i;

  // Pulses are counted at the falling edge, where they have settled.
  always @(negedge clk_i) begin
    n_rr += int'(reread_req_o === 1'b1);
    n_wv += int'(wv_req_o === 1'b1);
    n_sp += int'(spare_cmd_o === 1'b1);
    n_fwd += int'(host_fwd_o === 1'b1);
    n_corr += int'(corr_apply_o === 1'b1);
    if (wv_req_o === 1'b1) sid_seen = wv_special_id_o;
    if (spare_cmd_o === 1'b1) begin
      inl_seen = spare_inline_o;
      cyl_seen = spare_cyl_o;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Classic bus cycle; a missing ack ends the run.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    if (i >= 50) begin
      mismatches++;
      conclude();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // One recovery: set channel and control, raise error, wait for done.
  task automatic rec(input logic [15:0] ctrl, input logic [7:0] ok, input logic st, bd, wf, pr);
    int i;
    @(posedge clk_i);
    clr_i <= 1'b1;
    {ok_at_i, stable_i, bad_ilv_i, wv_fail_i, prior_unfix_i} <= {ok, st, bd, wf, pr};
    slow_i <= 1'($urandom);
    err_cyl_i <= 16'($urandom);
    @(posedge clk_i);
    clr_i <= 1'b0;
    wb(1'b1, REG_CTRL_OFS, {16'h0, ctrl}, rd);
    {n_rr, n_wv, n_sp, n_fwd, n_corr} = '0;
    @(posedge clk_i);
    err_i <= 1'b1;
    @(posedge clk_i);
    err_i <= 1'b0;
    for (i = 0; i < 3000 && done_o !== 1'b1; i++) @(negedge clk_i);
    if (i >= 3000) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic fd(input logic [15:0] cyl);
    @(posedge clk_i);
    fdef_i <= 1'b1;
    fdef_cyl_i <= cyl;
    @(posedge clk_i);
    fdef_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int k, r;
    logic [15:0] c;
    void'($urandom(84));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL_OFS, 32'h0, rd);
    chk("ctrl reset", {16'h0, RETRY_DEFAULT, 8'h00}, rd);
    wb(1'b0, REG_STATUS_OFS, 32'h0, rd);
    chk("status reset", 32'h0, rd);
    wb(1'b1, 8'h40, 32'hffff_ffff, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    repeat (3) begin
      k = $urandom_range(8, 1);
      rec(16'h0800, 8'(k), 1'b0, 1'b0, 1'b0, 1'b0);
      chk("soft res", 32'h1, result_o);
      chk("soft rr", k, n_rr);
      chk("soft fwd", 32'h1, n_fwd);
    end
    $display("test soft done");
    for (k = 0; k < 4; k++) begin
      r = (k == 0) ? 0 : (k == 1) ? 8 : $urandom_range(10, 1);
      c = {r[7:0], 4'h0, 4'($urandom) & 4'h8};
      rec(c, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("retries", r, n_rr);
      chk("unrec", 32'h3, result_o);
    end
    rec(16'h0802, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("stages", 32'd24, n_rr);
    chk("no wv", 32'h0, n_wv);
    $display("test limits done");
    rec(16'h0801, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("early res", 32'h2, result_o);
    chk("early rr", 32'h2, n_rr);
    chk("early apply", 32'h1, n_corr);
    wb(1'b0, REG_STATUS_OFS, 32'h0, rd);
    chk("hard flag", 32'h1, rd[2]);
    rec(16'h0802, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("stage3 res", 32'h2, result_o);
    chk("stage3 rr", 32'd17, n_rr);
    $display("test correction done");
    for (k = 0; k < 2; k++) begin
      wb(1'b0, REG_COUNT_OFS, 32'h0, rd);
      c = rd[31:16];
      rec(16'h0802, 8'h00, 1'b1, 1'b0, k[0], 1'b0);
      chk("stage2 res", 32'h2, result_o);
      wb(1'b0, REG_STATUS_OFS, 32'h0, rd);
      chk("eligible", 32'h1, rd[1]);
      chk("spare count", k, n_sp);
      if (k == 0) chk("wv passes", 32'd10, n_wv);
      else chk("grown spare", {16'h0, err_cyl_i}, {15'h0, inl_seen, cyl_seen});
      wb(1'b0, REG_COUNT_OFS, 32'h0, rd);
      chk("grown cnt", c + 16'(k), rd[31:16]);
    end
    for (k = 0; k < 2; k++) begin
      rec(k ? 16'h0806 : 16'h0802, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      chk("unfix", 32'h3, result_o);
      chk("unfix wv", k * 10, n_wv);
      if (k == 1) chk("special id", 32'h1, sid_seen);
    end
    rec(16'h0800, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("flag sense", 32'h3aa, {sense_key_o, sense_code_o});
    $display("test reallocation done");
    k = $urandom_range(63, 0);
    n_sp = 0;
    fd(16'(k));
    chk("inline", 32'h1, inl_seen);
    fd(16'(k + 64));
    chk("nearby", 32'h0, inl_seen);
    chk("spares", 32'h2, n_sp);
    $display("test factory done");
    conclude();
  end
endmodule
